// File: logic/fgpm_ctrl.sv
// power-mode controller of the battery monitor with APB register access
// Function
// - Hold reset below threshold; load defaults, then Run
// - Run converts continuously; half-second updates
// - Stay in Run absent other modes
// - Sample bit enters Sample; clear returns Run
// - Sample interval is two-power divider halves
// - Updates keep half-second rate in sample modes
// - Sample-Sleep: analog off, one conversion set
// - Three enabled causes or the command enter Sample-Sleep
// - Sleep interval multiplies both divider powers
// - Leave Sample-Sleep on clear or wake
// - Charge-current wake above threshold when enabled
// - Pack-voltage wake above threshold when enabled
// - Shelf: no conversion, accumulation or bus
// - Shelf armed by command or voltage trip
// - Enter shelf after lines held low
// - Leave shelf after lines held high
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "fgpm_regs.svh"
module fgpm_ctrl
   import fgpm_pkg::*;
#(
   parameter int TICK_CYC = `FGPM_TICK_CYC,
   parameter int SHELF_ENTRY_CYC = `FGPM_SHELF_ENTRY_CYC,
   parameter int SHELF_WAKE_CYC = `FGPM_SHELF_WAKE_CYC,
   parameter int SLEEP_DIV = `FGPM_SLEEP_DIV,
   parameter logic [7:0] DEF_MODE = 8'h00,
   parameter logic [15:0] DEF_CONV = 16'h0100,
   parameter logic [7:0] DEF_TRIP = 8'h00,
   parameter logic [15:0] DEF_CELL = 16'h0000,
   parameter logic [15:0] DEF_PWAKE = 16'h0000,
   parameter logic [15:0] DEF_SHELFT = 16'h0000,
   parameter logic [31:0] DEF_ITRIP = 32'h0000_0000
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pack_above_por,
   input wire logic [15:0] pack_voltage_input,
   input wire logic [15:0] aux_voltage_input,
   input wire logic [15:0] current_meas,
   input wire logic nvm_done,
   input wire logic sda_in,
   input wire logic scl_in,
   output logic nvm_load,
   output logic analog_on,
   output logic conv_start,
   output logic accum_tick,
   output logic bus_enable,
   output logic [2:0] mode
);
   initial begin
      if (SLEEP_DIV < 1) $error("fgpm_ctrl: SLEEP_DIV must be at least 1");
   end
   fgpm_mode_t state, next_state;
   logic [7:0] operating_mode_control;
   logic [15:0] converter_configuration;
   logic [7:0] trip_control;
   logic [15:0] cell_low_threshold, pack_wake_threshold, shelf_trip_threshold;
   logic [31:0] current_trip;
   logic sample_sleep_cmd, shelf_cmd, sample_bit;
   logic [2:0] sample_divider, sleep_divider, conv_count;
   logic pack_low_sleep_enable, aux_low_sleep_enable, ilow_sleep_enable;
   logic pack_wake_enable, iwake_enable, shelf_trip_enable;
   assign sample_sleep_cmd = operating_mode_control[`FGPM_MODE_SAMPLE_SLEEP_CMD];
   assign shelf_cmd = operating_mode_control[`FGPM_MODE_SHELF];
   assign sleep_divider = operating_mode_control[`FGPM_MODE_DIV_LO +: 3];
   assign sample_bit = converter_configuration[`FGPM_CONV_SAMP];
   assign sample_divider = converter_configuration[`FGPM_CONV_DIV_LO +: 3];
   assign conv_count = converter_configuration[`FGPM_CONV_NUM_LO +: 3];
   assign pack_low_sleep_enable = trip_control[`FGPM_TRIP_PENT];
   assign aux_low_sleep_enable = trip_control[`FGPM_TRIP_AENT];
   assign ilow_sleep_enable = trip_control[`FGPM_TRIP_IENT];
   assign pack_wake_enable = trip_control[`FGPM_TRIP_PEX];
   assign iwake_enable = trip_control[`FGPM_TRIP_IEX];
   assign shelf_trip_enable = trip_control[`FGPM_TRIP_SHENT];

   // current is signed: negative means charging
   logic [15:0] cur_mag;
   logic charging;
   assign charging = current_meas[15];
   assign cur_mag = charging ? 16'(-current_meas) : current_meas;

   logic enter_ssleep, wake_ss, shelf_armed, shelf_go, shelf_wake;
   assign enter_ssleep = (pack_low_sleep_enable && pack_voltage_input < cell_low_threshold)
      || (aux_low_sleep_enable && aux_voltage_input < cell_low_threshold)
      || sample_sleep_cmd
      || (ilow_sleep_enable && cur_mag < current_trip[15:0]);
   assign wake_ss = (iwake_enable && charging && cur_mag > current_trip[31:16])
      || (pack_wake_enable && pack_voltage_input > pack_wake_threshold);
   assign shelf_armed = shelf_cmd
      || (shelf_trip_enable && pack_voltage_input < shelf_trip_threshold);

   fgpm_hold #(.HOLD_CYC(SHELF_ENTRY_CYC), .LEVEL(1'b0)) u_entry (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .arm(shelf_armed && state != FGPM_SHELF && state != FGPM_RESET && state != FGPM_LOAD),
      .line_a(sda_in),
      .line_b(scl_in),
      .held(shelf_go)
   );
   fgpm_hold #(.HOLD_CYC(SHELF_WAKE_CYC), .LEVEL(1'b1)) u_wake (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .arm(state == FGPM_SHELF),
      .line_a(sda_in),
      .line_b(scl_in),
      .held(shelf_wake)
   );

   // sleep-latch: once woken, sample-sleep re-entry needs the cause to clear first
   logic ss_woken;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ss_woken <= 1'b0;
      end else if (!enter_ssleep || state == FGPM_RESET) begin
         ss_woken <= 1'b0;
      end else if (state == FGPM_SSLEEP && wake_ss) begin
         ss_woken <= 1'b1;
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         FGPM_RESET: begin
            if (pack_above_por) next_state = FGPM_LOAD;
         end
         FGPM_LOAD: begin
            if (nvm_done) next_state = FGPM_RUN;
         end
         FGPM_SHELF: begin
            if (shelf_wake) next_state = FGPM_RUN;
         end
         default: begin
            if (shelf_go) begin
               next_state = FGPM_SHELF;
            end else if (state == FGPM_SSLEEP) begin
               if (!enter_ssleep || wake_ss) next_state = FGPM_RUN;
            end else if (enter_ssleep && !ss_woken) begin
               next_state = FGPM_SSLEEP;
            end else if (sample_bit) begin
               next_state = FGPM_SAMPLE;
            end else begin
               next_state = FGPM_RUN;
            end
         end
      endcase
      if (!pack_above_por) next_state = FGPM_RESET;
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= FGPM_RESET;
      end else begin
         state <= next_state;
      end
   end

   logic active;
   assign active = state == FGPM_RUN || state == FGPM_SAMPLE || state == FGPM_SSLEEP;
   logic tick;
   fgpm_tick #(.TICK_CYC(TICK_CYC)) u_tick (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .run_en(active),
      .tick(tick)
   );
   assign accum_tick = tick;

   // interval in half-second ticks; sample-sleep multiplies both powers
   // both dividers at seven give two to the fourteenth: fifteen bits, or the period wraps to 0
   logic [14:0] period, tick_cnt;
   always_comb begin
      period = 15'(1) << sample_divider;
      if (state == FGPM_SSLEEP) begin
         period = 15'(1) << (4'(sample_divider) + 4'(sleep_divider));
      end
   end
   logic interval_due;
   assign interval_due = tick && (tick_cnt + 15'h1 >= period);
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tick_cnt <= 15'h0;
      end else if (!active || interval_due) begin
         tick_cnt <= 15'h0;
      end else if (tick) begin
         tick_cnt <= tick_cnt + 15'h1;
      end
   end

   // conversion sequencer: conversions are a fixed slot each
   logic [2:0] conv_left;
   logic [7:0] slot;
   logic conv_busy;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         conv_busy <= 1'b0;
         conv_left <= 3'h0;
         slot <= 8'h0;
      end else if (!active) begin
         conv_busy <= 1'b0;
         conv_left <= 3'h0;
         slot <= 8'h0;
      end else if (!conv_busy) begin
         if (state == FGPM_RUN || interval_due) begin
            conv_busy <= 1'b1;
            conv_left <= conv_count;
            slot <= 8'h0;
         end
      end else if (slot == 8'(`FGPM_CONV_CYC - 1)) begin
         slot <= 8'h0;
         if (conv_left == 3'h0) conv_busy <= 1'b0;
         else conv_left <= conv_left - 3'h1;
      end else begin
         slot <= slot + 8'h1;
      end
   end
   // sequencer clears one edge late on leaving the active modes; gate so shelf stays quiet
   assign conv_start = active && conv_busy && slot == 8'h0;
   // sleep portion shuts analog down between sets
   assign analog_on = (state == FGPM_RUN || state == FGPM_SAMPLE)
      || (state == FGPM_SSLEEP && conv_busy);
   assign nvm_load = state == FGPM_LOAD;
   assign bus_enable = active;
   assign mode = state;

   // APB slave, zero wait states; config loaded while in load, lost in reset/shelf
   logic wr, rd;
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite && bus_enable;
   assign rd = psel && penable && !pwrite;
   logic hit;
   always_comb begin
      hit = 1'b1;
      unique case (paddr)
         `FGPM_OFF_MODE, `FGPM_OFF_CONV, `FGPM_OFF_TRIP, `FGPM_OFF_CELL,
         `FGPM_OFF_PWAKE, `FGPM_OFF_SHELFT, `FGPM_OFF_ITRIP, `FGPM_OFF_STAT,
         `FGPM_OFF_MEAS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && (!hit || !bus_enable);
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         operating_mode_control <= 8'h00;
         converter_configuration <= 16'h0000;
         trip_control <= 8'h00;
         cell_low_threshold <= 16'h0000;
         pack_wake_threshold <= 16'h0000;
         shelf_trip_threshold <= 16'h0000;
         current_trip <= 32'h0000_0000;
      end else if (state == FGPM_LOAD || state == FGPM_RESET || state == FGPM_SHELF) begin
         operating_mode_control <= DEF_MODE;
         converter_configuration <= DEF_CONV;
         trip_control <= DEF_TRIP;
         cell_low_threshold <= DEF_CELL;
         pack_wake_threshold <= DEF_PWAKE;
         shelf_trip_threshold <= DEF_SHELFT;
         current_trip <= DEF_ITRIP;
      end else if (wr) begin
         unique case (paddr)
            `FGPM_OFF_MODE: operating_mode_control <= pwdata[7:0];
            `FGPM_OFF_CONV: converter_configuration <= pwdata[15:0];
            `FGPM_OFF_TRIP: trip_control <= pwdata[7:0];
            `FGPM_OFF_CELL: cell_low_threshold <= pwdata[15:0];
            `FGPM_OFF_PWAKE: pack_wake_threshold <= pwdata[15:0];
            `FGPM_OFF_SHELFT: shelf_trip_threshold <= pwdata[15:0];
            `FGPM_OFF_ITRIP: current_trip <= pwdata;
            default: begin
            end
         endcase
      end
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `FGPM_OFF_MODE: prdata <= {24'h0, operating_mode_control};
            `FGPM_OFF_CONV: prdata <= {16'h0, converter_configuration};
            `FGPM_OFF_TRIP: prdata <= {24'h0, trip_control};
            `FGPM_OFF_CELL: prdata <= {16'h0, cell_low_threshold};
            `FGPM_OFF_PWAKE: prdata <= {16'h0, pack_wake_threshold};
            `FGPM_OFF_SHELFT: prdata <= {16'h0, shelf_trip_threshold};
            `FGPM_OFF_ITRIP: prdata <= current_trip;
            `FGPM_OFF_STAT: prdata <= {22'h0, shelf_armed, wake_ss, enter_ssleep,
               conv_busy, analog_on, 2'h0, state};
            `FGPM_OFF_MEAS: prdata <= {pack_voltage_input, current_meas};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
   logic unused_rd;
   assign unused_rd = rd;
endmodule

// File: logic/fgpm_regs.svh
// register offsets, fields and timing counts of the power-mode controller
`ifndef FGPM_REGS_SVH
`define FGPM_REGS_SVH
`define FGPM_CLK_HZ 50000000
`define FGPM_TICK_MS 500
`define FGPM_TICK_CYC ((`FGPM_CLK_HZ / 1000) * `FGPM_TICK_MS)
`define FGPM_SHELF_ENTRY_US 2000
`define FGPM_SHELF_ENTRY_CYC (((`FGPM_CLK_HZ / 1000000) * `FGPM_SHELF_ENTRY_US))
`define FGPM_SHELF_WAKE_US 1000
`define FGPM_SHELF_WAKE_CYC (((`FGPM_CLK_HZ / 1000000) * `FGPM_SHELF_WAKE_US))
`define FGPM_LOAD_CYC 16
`define FGPM_CONV_CYC 64
`define FGPM_SLEEP_DIV 1000
`define FGPM_OFF_MODE 12'h000
`define FGPM_OFF_CONV 12'h004
`define FGPM_OFF_TRIP 12'h008
`define FGPM_OFF_CELL 12'h00C
`define FGPM_OFF_PWAKE 12'h010
`define FGPM_OFF_SHELFT 12'h014
`define FGPM_OFF_ITRIP 12'h018
`define FGPM_OFF_STAT 12'h01C
`define FGPM_OFF_MEAS 12'h020
`define FGPM_MODE_SAMPLE_SLEEP_CMD 0
`define FGPM_MODE_SHELF 1
`define FGPM_MODE_DIV_LO 4
`define FGPM_CONV_SAMP 0
`define FGPM_CONV_DIV_LO 4
`define FGPM_CONV_NUM_LO 8
`define FGPM_TRIP_PENT 0
`define FGPM_TRIP_AENT 1
`define FGPM_TRIP_IENT 2
`define FGPM_TRIP_PEX 3
`define FGPM_TRIP_IEX 4
`define FGPM_TRIP_SHENT 5
`endif

// File: logic/fgpm_pkg.sv
// types of the power-mode controller
package fgpm_pkg;
   typedef enum logic [2:0] {
      FGPM_RESET = 3'h0,
      FGPM_LOAD = 3'h1,
      FGPM_RUN = 3'h3,
      FGPM_SAMPLE = 3'h2,
      FGPM_SSLEEP = 3'h6,
      FGPM_SHELF = 3'h7
   } fgpm_mode_t;
endpackage

// File: logic/fgpm_tick.sv
// half-second update tick, counting only while run_en is high and cleared when it is low
`timescale 1ns/1ps
`include "fgpm_regs.svh"
module fgpm_tick #(
   parameter int TICK_CYC = `FGPM_TICK_CYC
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic run_en,
   output logic tick
);
   initial begin
      if (TICK_CYC < 1) $error("fgpm_tick: TICK_CYC must be at least 1");
   end
   logic [31:0] cnt;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt <= 32'h0;
      end else if (!run_en || cnt == 32'(TICK_CYC - 1)) begin
         cnt <= 32'h0;
      end else begin
         cnt <= cnt + 32'h1;
      end
   end
   assign tick = run_en && cnt == 32'(TICK_CYC - 1);
endmodule

// File: logic/fgpm_hold.sv
// detects both bus lines held at one level for a minimum time
`timescale 1ns/1ps
module fgpm_hold #(
   parameter int HOLD_CYC = 100,
   parameter bit LEVEL = 1'b0
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic arm,
   input wire logic line_a,
   input wire logic line_b,
   output logic held
);
   initial begin
      if (HOLD_CYC < 1) $error("fgpm_hold: HOLD_CYC must be at least 1");
   end
   logic [31:0] cnt;
   logic seen_other;
   logic at_level;
   assign at_level = (line_a == LEVEL) && (line_b == LEVEL);
   // a change of level is needed: lines already at the target level on arming do not count
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         seen_other <= 1'b0;
      end else if (!arm) begin
         seen_other <= 1'b0;
      end else if (!at_level) begin
         seen_other <= 1'b1;
      end
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt <= 32'h0;
      end else if (!arm || !at_level || !seen_other) begin
         cnt <= 32'h0;
      end else if (cnt != 32'(HOLD_CYC)) begin
         cnt <= cnt + 32'h1;
      end
   end
   assign held = arm && cnt == 32'(HOLD_CYC);
endmodule

// File: sim/fgpm_ctrl_properties.sv
// port-level checks of the power-mode controller
`timescale 1ns/1ps
module fgpm_ctrl_properties #(
   parameter int TICK_CYC = 20
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pack_above_por,
   input wire logic nvm_done,
   input wire logic sda_in,
   input wire logic scl_in,
   input wire logic nvm_load,
   input wire logic analog_on,
   input wire logic conv_start,
   input wire logic accum_tick,
   input wire logic bus_enable,
   input wire logic [2:0] mode
);
   int gap;
   logic active;
   assign active = mode == 3'h3 || mode == 3'h2 || mode == 3'h6;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // cycles since the last update tick; a small slack covers mode entry
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) gap <= 0;
      else if (accum_tick || !active) gap <= 0;
      else gap <= gap + 1;
   end
   sequence lines_up;
      (sda_in && scl_in) [*8];
   endsequence
   sequence shelf_low;
      mode == 3'h7 && !(sda_in && scl_in);
   endsequence
   chk_por_reset: assert property (!pack_above_por |=> mode == 3'h0)
      else $error("mode not reset without supply");
   chk_por_load: assert property (mode == 3'h0 && pack_above_por |=> mode == 3'h1)
      else $error("no default load after supply rise");
   chk_load_run: assert property (mode == 3'h1 && nvm_done && pack_above_por
      |=> mode == 3'h3)
      else $error("no run after default load");
   chk_load_flag: assert property (nvm_load == (mode == 3'h1))
      else $error("load request outside load state");
   chk_shelf_quiet: assert property (mode == 3'h7 |->
      !(conv_start || accum_tick || bus_enable || analog_on))
      else $error("activity in shelf");
   chk_shelf_deaf: assert property (mode == 3'h7 && psel && penable && pwrite |-> pslverr)
      else $error("shelf write not refused");
   chk_tick_gap: assert property (accum_tick |=> !accum_tick [*8])
      else $error("update ticks too close");
   chk_tick_live: assert property (gap < TICK_CYC + 4)
      else $error("update tick missing");
   chk_sleep_conv: assert property (mode == 3'h6 && conv_start |-> analog_on)
      else $error("conversion with analog off");
   chk_shelf_wake: assert property (shelf_low ##1 (mode == 3'h7 throughout lines_up)
      |-> ##[0:4] mode != 3'h7)
      else $error("no wake from shelf");
   chk_bus_ready: assert property (pready)
      else $error("ready low");
   chk_bad_addr: assert property (psel && penable && paddr > 12'h020 |-> pslverr)
      else $error("unmapped access not flagged");
endmodule

// File: sim/fgpm_pack_model.sv
// battery pack, bus lines and default store as the controller sees them
`timescale 1ns/1ps
module fgpm_pack_model #(
   parameter int NVM_CYC = 5
) (
   input wire logic clk_sys,
   input wire logic supply_on,
   input wire logic lines_low,
   input wire logic [15:0] pv_set,
   input wire logic [15:0] av_set,
   input wire logic [15:0] cur_set,
   input wire logic nvm_load,
   output logic pack_above_por = 1'b0,
   output logic [15:0] pack_voltage_input = 16'h0000,
   output logic [15:0] aux_voltage_input = 16'h0000,
   output logic [15:0] current_meas = 16'h0000,
   output logic nvm_done = 1'b0,
   output logic sda_in = 1'b1,
   output logic scl_in = 1'b1
);
   int cnt = 0;
   // without supply the sense pins read zero, not the last level
   always_ff @(posedge clk_sys) begin
      pack_above_por <= supply_on;
      pack_voltage_input <= supply_on ? pv_set : 16'h0000;
      aux_voltage_input <= supply_on ? av_set : 16'h0000;
      current_meas <= supply_on ? cur_set : 16'h0000;
   end
   // store answers slowly and only while asked
   always_ff @(posedge clk_sys) begin
      cnt <= nvm_load ? cnt + 1 : 0;
      nvm_done <= nvm_load && cnt >= NVM_CYC;
   end
   // pulled-up lines; host or unplugging holds both low
   always_ff @(posedge clk_sys) begin
      sda_in <= !lines_low;
      scl_in <= !lines_low;
   end
endmodule

// File: sim/fgpm_ctrl_bench.sv
// self-checking bench of the power-mode controller
`timescale 1ns/1ps
module fgpm_ctrl_bench;
   typedef struct {
      logic [11:0] a;
      logic [31:0] d;
      logic [15:0] pv;
      logic [15:0] av;
      logic [15:0] cur;
      logic [2:0] m;
   } fgpm_row_t;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, pack_above_por, nvm_done, sda_in, scl_in, er;
   logic nvm_load, analog_on, conv_start, accum_tick, bus_enable;
   logic [2:0] mode;
   logic [15:0] pack_voltage_input, aux_voltage_input, current_meas;
   logic supply_on = 1'b0, lines_low = 1'b0;
   logic [15:0] pv_set = 16'h2000, av_set = 16'h2000, cur_set = 16'h0800;
   int n_errors = 0, checks_done = 0, nc, nt, na;
   fgpm_row_t rows [14] = '{
      '{12'h004, 32'h1, 16'h2000, 16'h2000, 16'h0800, 3'h2},
      '{12'h004, 32'h0, 16'h2000, 16'h2000, 16'h0800, 3'h3},
      '{12'h000, 32'h1, 16'h2000, 16'h2000, 16'h0800, 3'h6},
      '{12'h000, 32'h0, 16'h2000, 16'h2000, 16'h0800, 3'h3},
      '{12'h004, 32'h1, 16'h2000, 16'h2000, 16'h0800, 3'h2},
      '{12'h000, 32'h1, 16'h2000, 16'h2000, 16'h0800, 3'h6},
      '{12'h000, 32'h0, 16'h2000, 16'h2000, 16'h0800, 3'h2},
      '{12'h004, 32'h0, 16'h2000, 16'h2000, 16'h0800, 3'h3},
      '{12'h008, 32'h9, 16'h0800, 16'h2000, 16'h0800, 3'h6},
      '{12'h010, 32'h3000, 16'h4000, 16'h2000, 16'h0800, 3'h3},
      '{12'h008, 32'h12, 16'h4000, 16'h0100, 16'h0800, 3'h6},
      '{12'h018, 32'h0400_0200, 16'h4000, 16'h0100, 16'hF000, 3'h3},
      '{12'h008, 32'h4, 16'h4000, 16'h2000, 16'h0010, 3'h6},
      '{12'h008, 32'h8, 16'h4000, 16'h2000, 16'h0010, 3'h3}
   };
   // short tick and line-hold counts keep the run brief
   fgpm_ctrl #(.TICK_CYC(200), .SHELF_ENTRY_CYC(8), .SHELF_WAKE_CYC(8)) u_fgpm_ctrl (
      .clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .pack_above_por, .pack_voltage_input, .aux_voltage_input, .current_meas,
      .nvm_done, .sda_in, .scl_in, .nvm_load, .analog_on, .conv_start, .accum_tick,
      .bus_enable, .mode);
   fgpm_pack_model u_fgpm_pack_model (
      .clk_sys, .supply_on, .lines_low, .pv_set, .av_set, .cur_set, .nvm_load,
      .pack_above_por, .pack_voltage_input, .aux_voltage_input, .current_meas,
      .nvm_done, .sda_in, .scl_in);
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wmode(input logic [2:0] m);
      int k;
      k = 0;
      while (mode !== m && k < 3000) begin
         @(posedge clk_sys);
         k++;
      end
      chk(32'(mode), 32'(m));
   endtask
   task automatic count(input int n);
      nc = 0;
      nt = 0;
      na = 0;
      repeat (n) begin
         @(posedge clk_sys);
         nc = nc + (conv_start === 1'b1);
         nt = nt + (accum_tick === 1'b1);
         na = na + (analog_on === 1'b0);
      end
   endtask
   initial forever #10 clk_sys = ~clk_sys;
   initial begin
      repeat (80000) @(posedge clk_sys);
      n_errors++;
      wrap_up;
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      chk(32'(mode), 32'h0);
      chk(32'(pready), 32'h1);
      resetn <= 1'b1;
      supply_on <= 1'b1;
      wmode(3'h1);
      wmode(3'h3);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h100);
      apb(1'b0, 12'h024, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      apb(1'b1, 12'h00C, 32'h1000);
      apb(1'b1, 12'h010, 32'h3000);
      apb(1'b1, 12'h018, 32'h0400_0200);
      $display("power-up and defaults done");
      foreach (rows[i]) begin
         pv_set <= rows[i].pv;
         av_set <= rows[i].av;
         cur_set <= rows[i].cur;
         apb(1'b1, rows[i].a, rows[i].d);
         wmode(rows[i].m);
      end
      $display("mode table done");
      // the table leaves pack wake armed above threshold; it would cut sleep short
      apb(1'b1, 12'h008, 32'h0);
      // two conversions per set; wait out any set begun before the mode change
      apb(1'b1, 12'h004, 32'h121);
      wmode(3'h2);
      repeat (100) @(posedge clk_sys);
      count(3200);
      chk(32'(nc), 32'h8);
      chk(32'(nt), 32'h10);
      apb(1'b1, 12'h000, 32'h11);
      wmode(3'h6);
      repeat (100) @(posedge clk_sys);
      count(3200);
      chk(32'(nc), 32'h4);
      chk(32'(nt), 32'h10);
      chk(32'(na > 0), 32'h1);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h0);
      wmode(3'h3);
      $display("interval tests done");
      // unarmed lines held low must not put the part to shelf
      lines_low <= 1'b1;
      repeat (40) @(posedge clk_sys);
      chk(32'(mode), 32'h3);
      lines_low <= 1'b0;
      apb(1'b1, 12'h000, 32'h2);
      repeat (5) @(posedge clk_sys);
      lines_low <= 1'b1;
      wmode(3'h7);
      apb(1'b1, 12'h004, 32'h1);
      chk(32'(er), 32'h1);
      lines_low <= 1'b0;
      wmode(3'h3);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      $display("shelf tests done");
      supply_on <= 1'b0;
      wmode(3'h0);
      supply_on <= 1'b1;
      wmode(3'h3);
      $display("supply loss test done");
      wrap_up;
   end
endmodule
bind fgpm_ctrl fgpm_ctrl_properties #(.TICK_CYC(TICK_CYC)) u_chk (
   .clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
   .pack_above_por, .nvm_done, .sda_in, .scl_in, .nvm_load, .analog_on,
   .conv_start, .accum_tick, .bus_enable, .mode);
